/* File: exec_defs.sv */
package exec_pkg;
    // status register bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    // cycle counts
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_MUL = 2'h2;
    localparam logic [1:0] CYC_INDIRECT_JUMP = 2'h2;
    localparam logic [1:0] CYC_INDIRECT_CALL = 2'h3;
    localparam logic [1:0] CYC_TAKEN = 2'h2;
    localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
    localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
    // program counter steps
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [15:0] SKIP_ONE_WORD = 16'h0002;
    localparam logic [15:0] SKIP_TWO_WORD = 16'h0003;

    typedef enum logic [4:0] {
        op_none,
        op_mul_signed_by_unsigned,
        op_frac_mul_unsigned,
        op_frac_mul_signed,
        op_frac_mul_signed_by_unsigned,
        op_indirect_jump,
        op_indirect_call,
        op_compare_skip_equal,
        op_compare_immediate,
        op_skip_reg_bit_clear,
        op_skip_reg_bit_set,
        op_skip_io_bit_clear,
        op_skip_io_bit_set,
        op_branch_flag_set,
        op_branch_flag_clear,
        op_branch_signed_ge,
        op_branch_signed_less,
        op_branch_same_or_higher,
        op_branch_lower,
        op_branch_half_carry_set,
        op_branch_half_carry_clear,
        op_branch_transfer_bit_set,
        op_branch_transfer_bit_clear,
        op_branch_overflow_set
    } op_t;

    typedef struct packed {
        op_t op;
        logic [15:0] pc;
        logic [7:0] rd;
        logic [7:0] rr;
        logic [7:0] imm;
        logic [7:0] io_value;
        logic [2:0] bit_sel;
        logic [6:0] offset;
        logic [15:0] z_pointer;
        logic next_two_word;
    } cmd_t;

    typedef struct packed {
        logic [15:0] pc_next;
        logic pair_write;
        logic [15:0] pair_value;
        logic status_write;
        logic [7:0] status_value;
        logic push_en;
        logic [15:0] push_addr;
    } result_t;
endpackage : exec_pkg

/* File: mult_unit.sv */
`timescale 1ns/100ps
module mult_unit (
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic a_signed,
    input wire logic b_signed,
    input wire logic frac,
    output logic [15:0] product,
    output logic carry,
    output logic zero
);
    // nine-bit extension lets one signed multiplier cover all variants
    wire logic signed [8:0] a_ext = {a_signed & a[7], a};
    wire logic signed [8:0] b_ext = {b_signed & b[7], b};
    wire logic signed [17:0] full = a_ext * b_ext;
    wire logic [15:0] raw = full[15:0];
    // carry is taken before the shift
    assign carry = raw[15];
    assign product = frac ? {raw[14:0], 1'b0} : raw;
    assign zero = (product == 16'h0000);
endmodule : mult_unit

/* File: branch_skip_multiply_exec.sv */
`timescale 1ns/100ps
//
// Overview of operation
// - Signed-by-unsigned multiply writes the 16-bit product to the pair, sets Z and C, takes 2 cycles.
// - The three fractional multiplies shift the product left by one, set Z and C, take 2 cycles.
// - Indirect jump loads the pc from the pointer pair, keeps flags, takes 2 cycles.
// - Indirect call loads the pc from the pointer pair, keeps flags, takes 3 cycles.
// - Compare-skip-equal skips the next instruction when both registers match, keeping flags.
// - Compare-immediate subtracts the constant without write-back and sets Z, N, V, C, H in 1 cycle.
// - Register-bit skips skip when the chosen bit is clear, or set for the set variant.
// - I/O-bit skips skip when the chosen I/O bit is set, or clear for the clear variant.
// - Generic flag branches add offset plus one when the chosen flag is set or clear, in 1 or 2 cycles.
// - Signed ge branches on N xor V equal 0 and signed less on 1, in 1 or 2 cycles.
// - Same-or-higher branches on carry 0 and lower on carry 1, in 1 or 2 cycles.
// - Half-carry branches are taken on H set, or clear for the clear variant.
// - Transfer-bit branches are taken on T set, or clear for the clear variant.
// - Overflow branch is taken on V set, adding offset plus one, in 1 or 2 cycles.
module branch_skip_multiply_exec (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire exec_pkg::cmd_t cmd,
    input wire logic [7:0] status_in,
    output logic busy,
    output logic done,
    output exec_pkg::result_t res
);
    typedef enum logic {st_idle, st_run} state_t;

    state_t state;
    logic [1:0] cnt;

    function automatic logic pick(input logic [7:0] v, input logic [2:0] i);
        pick = v[i];
    endfunction : pick

    wire logic accept = cmd_valid && (state == st_idle);
    wire exec_pkg::op_t op = cmd.op;

    wire logic is_mul = (op == exec_pkg::op_mul_signed_by_unsigned);
    wire logic is_frac = (op == exec_pkg::op_frac_mul_unsigned)
        || (op == exec_pkg::op_frac_mul_signed)
        || (op == exec_pkg::op_frac_mul_signed_by_unsigned);
    wire logic any_mul = is_mul || is_frac;
    wire logic a_signed = is_mul
        || (op == exec_pkg::op_frac_mul_signed)
        || (op == exec_pkg::op_frac_mul_signed_by_unsigned);
    wire logic b_signed = (op == exec_pkg::op_frac_mul_signed);

    wire logic [15:0] mul_product;
    wire logic mul_carry;
    wire logic mul_zero;

    mult_unit u_mult (
        .a(cmd.rd),
        .b(cmd.rr),
        .a_signed(a_signed),
        .b_signed(b_signed),
        .frac(is_frac),
        .product(mul_product),
        .carry(mul_carry),
        .zero(mul_zero)
    );

    wire logic [7:0] cd = cmd.rd;
    wire logic [7:0] ck = cmd.imm;
    wire logic [7:0] cr = cd - ck;
    wire logic cmp_h = (~cd[3] & ck[3]) | (ck[3] & cr[3]) | (cr[3] & ~cd[3]);
    wire logic cmp_c = (~cd[7] & ck[7]) | (ck[7] & cr[7]) | (cr[7] & ~cd[7]);
    wire logic cmp_v = (cd[7] & ~ck[7] & ~cr[7]) | (~cd[7] & ck[7] & cr[7]);
    wire logic cmp_n = cr[7];
    wire logic cmp_z = (cr == 8'h00);

    wire logic fc = status_in[exec_pkg::FLAG_C];
    wire logic fv = status_in[exec_pkg::FLAG_V];
    wire logic fn = status_in[exec_pkg::FLAG_N];
    wire logic fh = status_in[exec_pkg::FLAG_H];
    wire logic ft = status_in[exec_pkg::FLAG_T];
    wire logic flag_sel = pick(status_in, cmd.bit_sel);
    wire logic reg_bit = pick(cmd.rr, cmd.bit_sel);
    wire logic io_bit = pick(cmd.io_value, cmd.bit_sel);

    wire logic is_skip = (op == exec_pkg::op_compare_skip_equal)
        || (op == exec_pkg::op_skip_reg_bit_clear)
        || (op == exec_pkg::op_skip_reg_bit_set)
        || (op == exec_pkg::op_skip_io_bit_clear)
        || (op == exec_pkg::op_skip_io_bit_set);
    wire logic skip_cond =
        ((op == exec_pkg::op_compare_skip_equal) && (cmd.rd == cmd.rr))
        || ((op == exec_pkg::op_skip_reg_bit_clear) && !reg_bit)
        || ((op == exec_pkg::op_skip_reg_bit_set) && reg_bit)
        || ((op == exec_pkg::op_skip_io_bit_clear) && !io_bit)
        || ((op == exec_pkg::op_skip_io_bit_set) && io_bit);

    wire logic br_generic =
        ((op == exec_pkg::op_branch_flag_set) && flag_sel)
        || ((op == exec_pkg::op_branch_flag_clear) && !flag_sel);
    // signed compares on n xor v
    wire logic br_signed =
        ((op == exec_pkg::op_branch_signed_ge) && ((fn ^ fv) == 1'b0))
        || ((op == exec_pkg::op_branch_signed_less) && ((fn ^ fv) == 1'b1));
    wire logic br_unsigned =
        ((op == exec_pkg::op_branch_same_or_higher) && !fc)
        || ((op == exec_pkg::op_branch_lower) && fc);
    wire logic br_ht =
        ((op == exec_pkg::op_branch_half_carry_set) && fh)
        || ((op == exec_pkg::op_branch_half_carry_clear) && !fh)
        || ((op == exec_pkg::op_branch_transfer_bit_set) && ft)
        || ((op == exec_pkg::op_branch_transfer_bit_clear) && !ft);
    wire logic br_ovf = (op == exec_pkg::op_branch_overflow_set) && fv;
    wire logic br_taken = br_generic || br_signed || br_unsigned
        || br_ht || br_ovf;
    wire logic is_branch = (op >= exec_pkg::op_branch_flag_set)
        && (op <= exec_pkg::op_branch_overflow_set);

    wire logic [15:0] pc_inc = cmd.pc + exec_pkg::PC_STEP;
    wire logic [15:0] br_target = pc_inc + {{9{cmd.offset[6]}}, cmd.offset};
    // skip distance follows the skipped instruction length
    wire logic [15:0] skip_step = cmd.next_two_word
        ? exec_pkg::SKIP_TWO_WORD : exec_pkg::SKIP_ONE_WORD;
    wire logic [15:0] skip_target = cmd.pc + skip_step;
    wire logic [1:0] skip_cycles = cmd.next_two_word
        ? exec_pkg::CYC_SKIP_TWO : exec_pkg::CYC_SKIP_ONE;

    logic [1:0] next_cycles;
    exec_pkg::result_t next_res;

    always_comb begin
        next_res = '0;
        next_res.pc_next = pc_inc;
        next_res.status_value = status_in;
        next_res.push_addr = pc_inc;
        next_cycles = exec_pkg::CYC_ONE;
        case (op)
            exec_pkg::op_mul_signed_by_unsigned,
            exec_pkg::op_frac_mul_unsigned,
            exec_pkg::op_frac_mul_signed,
            exec_pkg::op_frac_mul_signed_by_unsigned: begin
                // product to pair, z and c updated
                next_res.pair_write = 1'b1;
                next_res.pair_value = mul_product;
                next_res.status_write = 1'b1;
                next_res.status_value[exec_pkg::FLAG_Z] = mul_zero;
                next_res.status_value[exec_pkg::FLAG_C] = mul_carry;
                next_cycles = exec_pkg::CYC_MUL;
            end
            exec_pkg::op_indirect_jump: begin
                next_res.pc_next = cmd.z_pointer;
                next_cycles = exec_pkg::CYC_INDIRECT_JUMP;
            end
            exec_pkg::op_indirect_call: begin
                // pc from pointer pair, return address pushed
                next_res.pc_next = cmd.z_pointer;
                next_res.push_en = 1'b1;
                next_cycles = exec_pkg::CYC_INDIRECT_CALL;
            end
            exec_pkg::op_compare_immediate: begin
                // flags only; s kept consistent as n xor v
                next_res.status_write = 1'b1;
                next_res.status_value[exec_pkg::FLAG_Z] = cmp_z;
                next_res.status_value[exec_pkg::FLAG_N] = cmp_n;
                next_res.status_value[exec_pkg::FLAG_V] = cmp_v;
                next_res.status_value[exec_pkg::FLAG_C] = cmp_c;
                next_res.status_value[exec_pkg::FLAG_H] = cmp_h;
                next_res.status_value[exec_pkg::FLAG_S] = cmp_n ^ cmp_v;
            end
            default: begin
                if (is_skip && skip_cond) begin
                    // skip by 2 or 3 words
                    next_res.pc_next = skip_target;
                    next_cycles = skip_cycles;
                end else if (is_branch && br_taken) begin
                    // offset plus one on a taken branch
                    next_res.pc_next = br_target;
                    next_cycles = exec_pkg::CYC_TAKEN;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= st_idle;
            cnt <= 2'h0;
            busy <= 1'b0;
            done <= 1'b0;
            res <= '0;
        end else begin
            done <= 1'b0;
            case (state)
                st_idle: begin
                    if (accept) begin
                        res <= next_res;
                        cnt <= next_cycles - 2'h1;
                        if (next_cycles == exec_pkg::CYC_ONE) begin
                            done <= 1'b1;
                        end else begin
                            busy <= 1'b1;
                            state <= st_run;
                        end
                    end
                end
                st_run: begin
                    cnt <= cnt - 2'h1;
                    if (cnt == 2'h1) begin
                        done <= 1'b1;
                        busy <= 1'b0;
                        state <= st_idle;
                    end
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // checks; two-cycle instructions: busy one cycle then done
    sequence two_cycle_s;
        (busy && !done) ##1 (done && !busy);
    endsequence

    sequence three_cycle_s;
        (busy && !done) [*2] ##1 (done && !busy);
    endsequence

    property mul_timing_p;
        @(posedge clk_sys) disable iff (!rst_n)
        (accept && is_mul) |-> ##1 two_cycle_s;
    endproperty

    mul_timing_a: assert property (mul_timing_p)
        else $error("multiply did not finish in two cycles");

    frac_shift_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (accept && is_frac) |-> ##1 (res.pair_value[0] == 1'b0
            && res.pair_write && busy) ##1 done)
        else $error("fractional product not shifted or late");

    indirect_jump_target_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (accept && op == exec_pkg::op_indirect_jump) |->
            ##1 (res.pc_next == $past(cmd.z_pointer)
            && !res.status_write) ##0 two_cycle_s)
        else $error("indirect jump target, flags or timing wrong");

    indirect_call_timing_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (accept && op == exec_pkg::op_indirect_call) |->
            ##1 (res.pc_next == $past(cmd.z_pointer) && res.push_en)
            ##0 three_cycle_s)
        else $error("indirect call target or timing wrong");

    cmp_zero_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (accept && op == exec_pkg::op_compare_immediate) |->
            ##1 (done && !res.pair_write
            && res.status_value[exec_pkg::FLAG_Z]
            == ($past(cmd.rd) == $past(cmd.imm))))
        else $error("compare immediate zero flag or timing wrong");

    skip_dist_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (accept && is_skip && skip_cond && cmd.next_two_word) |->
            ##1 (res.pc_next == $past(cmd.pc) + 16'h0003)
            ##0 three_cycle_s)
        else $error("two-word skip distance or timing wrong");

    eq_skip_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (accept && op == exec_pkg::op_compare_skip_equal
            && cmd.rd == cmd.rr && !cmd.next_two_word) |->
            ##1 (res.pc_next == $past(cmd.pc) + 16'h0002
            && !res.status_write) ##0 two_cycle_s)
        else $error("equal skip did not skip one word");

    ge_taken_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (accept && op == exec_pkg::op_branch_signed_ge && !(fn ^ fv)) |->
            ##1 (res.pc_next == $past(cmd.pc) + 16'h0001
            + {{9{$past(cmd.offset[6])}}, $past(cmd.offset)})
            ##0 two_cycle_s)
        else $error("signed ge branch not taken correctly");

    not_taken_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (accept && is_branch && !br_taken) |->
            ##1 (done && res.pc_next == $past(cmd.pc) + 16'h0001
            && !res.status_write))
        else $error("untaken branch must fall through in one cycle");

    lower_taken_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (accept && op == exec_pkg::op_branch_lower) |->
            ##1 (busy == $past(fc)))
        else $error("lower branch timing does not follow carry");
endmodule : branch_skip_multiply_exec

/* File: branch_skip_multiply_exec_bench.sv */
`timescale 1ns/100ps
module branch_skip_multiply_exec_bench;
    logic clk_sys;
    logic rst_n;
    logic cmd_valid;
    exec_pkg::cmd_t cmd;
    logic [7:0] status_in;
    logic busy;
    logic done;
    exec_pkg::result_t res;
    int mismatches = 0;
    int samples_checked = 0;
    int ticks = 0;

    branch_skip_multiply_exec dut (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .cmd_valid(cmd_valid),
        .cmd(cmd),
        .status_in(status_in),
        .busy(busy),
        .done(done),
        .res(res)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // the full sequence needs under 1500 cycles, so 5000 means a hang
    always @(posedge clk_sys) begin
        ticks <= ticks + 1;
        if (ticks == 5000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic test_done();
        $display("checked %0d mismatched %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    function automatic exec_pkg::cmd_t mk(input exec_pkg::op_t op);
        mk = '0;
        mk.op = op;
        mk.pc = 16'h1234;
        mk.z_pointer = 16'h0A5C;
    endfunction : mk

    // subtract flags worked out bit by bit, independent of the design
    function automatic logic [8:0] cpi_exp(input logic [7:0] s,
            input logic [7:0] d, input logic [7:0] k);
        logic [7:0] r;
        r = d - k;
        s[exec_pkg::FLAG_C] = (~d[7] & k[7]) | (k[7] & r[7]) | (r[7] & ~d[7]);
        s[exec_pkg::FLAG_H] = (~d[3] & k[3]) | (k[3] & r[3]) | (r[3] & ~d[3]);
        s[exec_pkg::FLAG_Z] = (r === 8'h00);
        s[exec_pkg::FLAG_N] = r[7];
        s[exec_pkg::FLAG_V] = (d[7] & ~k[7] & ~r[7]) | (~d[7] & k[7] & r[7]);
        s[exec_pkg::FLAG_S] = r[7] ^ s[exec_pkg::FLAG_V];
        return {1'b1, s};
    endfunction : cpi_exp

    function automatic logic cond(input exec_pkg::op_t op,
            input logic [7:0] s, input logic [2:0] b);
        case (op)
            exec_pkg::op_branch_flag_set: cond = s[b];
            exec_pkg::op_branch_flag_clear: cond = ~s[b];
            exec_pkg::op_branch_signed_ge: cond = ~(s[2] ^ s[3]);
            exec_pkg::op_branch_signed_less: cond = s[2] ^ s[3];
            exec_pkg::op_branch_same_or_higher: cond = ~s[0];
            exec_pkg::op_branch_lower: cond = s[0];
            exec_pkg::op_branch_half_carry_set: cond = s[5];
            exec_pkg::op_branch_half_carry_clear: cond = ~s[5];
            exec_pkg::op_branch_transfer_bit_set: cond = s[6];
            exec_pkg::op_branch_transfer_bit_clear: cond = ~s[6];
            default: cond = s[3];
        endcase
    endfunction : cond

    // entered just after a falling edge; one request, then wait for done
    task automatic run(input exec_pkg::cmd_t c, input logic [7:0] s,
            input logic [15:0] pc_e, input int cyc_e, input logic [16:0] pair_e,
            input logic [8:0] st_e, input logic [16:0] push_e);
        int k;
        cmd = c;
        status_in = s;
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        k = 1;
        while (done !== 1'b1 && k < 6) begin
            @(negedge clk_sys);
            k++;
        end
        check(k, cyc_e);
        check(busy, 1'b0);
        check(res.pc_next, pc_e);
        check(res.pair_write, pair_e[16]);
        if (pair_e[16]) check(res.pair_value, pair_e[15:0]);
        check(res.status_write, st_e[8]);
        if (st_e[8]) check(res.status_value, st_e[7:0]);
        check(res.push_en, push_e[16]);
        if (push_e[16]) check(res.push_addr, push_e[15:0]);
        @(negedge clk_sys);
    endtask : run

    task automatic test_mul();
        exec_pkg::cmd_t c;
        c = mk(exec_pkg::op_mul_signed_by_unsigned);
        c.rd = 8'hFF;
        c.rr = 8'hFF;
        run(c, 8'hA6, 16'h1235, 2, 17'h1FF01, 9'h1A5, '0);
        c.rd = 8'h00;
        run(c, 8'h01, 16'h1235, 2, 17'h10000, 9'h102, '0);
        c = mk(exec_pkg::op_frac_mul_unsigned);
        c.rd = 8'h80;
        c.rr = 8'h80;
        run(c, 8'hFF, 16'h1235, 2, 17'h18000, 9'h1FC, '0);
        c.op = exec_pkg::op_frac_mul_signed;
        c.rr = 8'h40;
        run(c, 8'hFF, 16'h1235, 2, 17'h1C000, 9'h1FD, '0);
        c.op = exec_pkg::op_frac_mul_signed_by_unsigned;
        c.rd = 8'hC0;
        c.rr = 8'hC0;
        run(c, 8'hFF, 16'h1235, 2, 17'h1A000, 9'h1FD, '0);
        $display("multiply test ended");
    endtask : test_mul

    task automatic test_indirect_cpi();
        logic [7:0] d[4];
        logic [7:0] k[4];
        d = '{8'h10, 8'h80, 8'h33, 8'h7F};
        k = '{8'h20, 8'h01, 8'h33, 8'hFF};
        run(mk(exec_pkg::op_indirect_jump), 8'h5A, 16'h0A5C, 2, '0, '0,
            '0);
        run(mk(exec_pkg::op_indirect_call), 8'h5A, 16'h0A5C, 3, '0, '0,
            17'h11235);
        run(mk(exec_pkg::op_none), 8'h5A, 16'h1235, 1, '0, '0, '0);
        foreach (d[i]) begin
            cmd = mk(exec_pkg::op_compare_immediate);
            cmd.rd = d[i];
            cmd.imm = k[i];
            run(cmd, 8'hC0, 16'h1235, 1, '0, cpi_exp(8'hC0, d[i], k[i]),
                '0);
        end
        $display("indirect and compare test ended");
    endtask : test_indirect_cpi

    task automatic test_skip();
        exec_pkg::op_t ops[5];
        exec_pkg::cmd_t c;
        logic [7:0] v;
        logic sk;
        int cyc;
        ops = '{exec_pkg::op_skip_reg_bit_clear, exec_pkg::op_skip_reg_bit_set,
            exec_pkg::op_skip_io_bit_clear, exec_pkg::op_skip_io_bit_set,
            exec_pkg::op_compare_skip_equal};
        for (int b = 0; b < 8; b++) begin
            foreach (ops[i]) begin
                for (int p = 0; p < 2; p++) begin
                    v = p ? ~(8'h01 << b) : (8'h01 << b);
                    c = mk(ops[i]);
                    c.bit_sel = 3'(b);
                    c.rr = (i < 2) ? v : ~v;
                    c.io_value = (i < 2) ? ~v : v;
                    c.rd = (p == 1) ? c.rr : v;
                    c.next_two_word = b[0];
                    sk = (i == 4) ? (c.rd === c.rr) : (v[b] === i[0]);
                    cyc = sk ? (b[0] ? 3 : 2) : 1;
                    run(c, 8'h3C, c.pc + 16'(cyc), cyc, '0, '0,
                        '0);
                end
            end
        end
        $display("skip test ended");
    endtask : test_skip

    task automatic test_branch();
        exec_pkg::op_t ops[11];
        logic [7:0] sv[10];
        exec_pkg::cmd_t c;
        logic [15:0] pc_e;
        logic t;
        ops = '{exec_pkg::op_branch_flag_set, exec_pkg::op_branch_flag_clear,
            exec_pkg::op_branch_signed_ge, exec_pkg::op_branch_signed_less,
            exec_pkg::op_branch_same_or_higher, exec_pkg::op_branch_lower,
            exec_pkg::op_branch_half_carry_set,
            exec_pkg::op_branch_half_carry_clear,
            exec_pkg::op_branch_transfer_bit_set,
            exec_pkg::op_branch_transfer_bit_clear,
            exec_pkg::op_branch_overflow_set};
        sv = '{8'h00, 8'hFF, 8'h04, 8'h08, 8'h0C, 8'h01, 8'h20, 8'h40, 8'h2A,
            8'hD5};
        foreach (ops[i]) begin
            foreach (sv[j]) begin
                c = mk(ops[i]);
                c.bit_sel = 3'(j);
                c.offset = j[0] ? 7'h40 : 7'h05;
                t = cond(ops[i], sv[j], c.bit_sel);
                pc_e = c.pc + 16'h0001;
                if (t) pc_e = pc_e + {{9{c.offset[6]}}, c.offset};
                run(c, sv[j], pc_e, t ? 2 : 1, '0, '0,
                    '0);
            end
        end
        $display("branch test ended");
    endtask : test_branch

    // a request held high while busy must wait for the done cycle
    task automatic test_chain();
        cmd = mk(exec_pkg::op_indirect_call);
        status_in = 8'h00;
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd = mk(exec_pkg::op_compare_immediate);
        cmd.rd = 8'h01;
        cmd.imm = 8'h01;
        check(busy, 1'b1);
        @(negedge clk_sys);
        check(done, 1'b0);
        @(negedge clk_sys);
        check(done, 1'b1);
        check(res.pc_next, 16'h0A5C);
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        check(done, 1'b1);
        check({res.status_write, res.status_value},
            cpi_exp(8'h00, 8'h01, 8'h01));
        @(negedge clk_sys);
        check(done, 1'b0);
        $display("chain test ended");
    endtask : test_chain

    task automatic test_reset();
        cmd = mk(exec_pkg::op_indirect_call);
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        rst_n = 1'b0;
        #1;
        check({busy, done, res === '0}, 3'h1);
        @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        check({busy, done}, 2'h0);
        run(mk(exec_pkg::op_indirect_jump), 8'h5A, 16'h0A5C, 2, '0, '0,
            '0);
        $display("reset test ended");
    endtask : test_reset

    initial begin
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        status_in = 8'h00;
        repeat (20) @(negedge clk_sys);
        check({busy, done, res === '0}, 3'h1);
        rst_n = 1'b1;
        @(negedge clk_sys);
        test_mul();
        test_indirect_cpi();
        test_skip();
        test_branch();
        test_chain();
        test_reset();
        test_done();
    end
endmodule : branch_skip_multiply_exec_bench
